// ### logic/lpp_pkg.sv
`default_nettype none

package lpp_pkg;

    // Core clock
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Pin-to-logic latency: two synchroniser stages, one output register
    localparam int unsigned SYNC_LAT = 2;
    localparam int unsigned OUT_LAT = 1;

    // Low-power entry, least time, rounded up to whole cycles
    localparam int unsigned LP_ENTRY_NS = 800;
    localparam int unsigned LP_ENTRY_CYC = (LP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Low-power exit, longest time, rounded down to whole cycles
    localparam int unsigned LP_EXIT_US = 200;
    localparam int unsigned LP_EXIT_CYC = (LP_EXIT_US * 1000) / CLK_PERIOD_NS;

    // Sequencer wait counts once the synchronised pin level is seen
    localparam int unsigned LP_ENTRY_WAIT = LP_ENTRY_CYC - SYNC_LAT - OUT_LAT;
    localparam int unsigned LP_EXIT_WAIT = LP_EXIT_CYC - SYNC_LAT - OUT_LAT;
    localparam int unsigned LP_CNT_W = 12;

    // Multifunction pin slots
    localparam int unsigned MF_NUM = 4;
    localparam int unsigned MF_PROBE_A = 0;
    localparam int unsigned MF_PROBE_B = 1;
    localparam int unsigned MF_SER_IN = 2;
    localparam int unsigned MF_SER_OUT = 3;
    localparam int unsigned QCLK_NUM = 4;

    // Slots of the synchronised input vector
    localparam int unsigned SY_LP = 0;
    localparam int unsigned SY_MODE = 1;
    localparam int unsigned SY_LOCK = 2;
    localparam int unsigned SY_CHK = 3;
    localparam int unsigned SY_DOWNLOAD_CLOCK = 4;
    localparam int unsigned SY_MF = 5;
    localparam int unsigned SY_QCLK = SY_MF + MF_NUM;
    localparam int unsigned SY_W = SY_QCLK + QCLK_NUM;

    typedef enum logic [1:0] {
        LPP_ROLE_USER,
        LPP_ROLE_DRIVE,
        LPP_ROLE_LISTEN,
        LPP_ROLE_OFF
    } lpp_role_t;

endpackage

`default_nettype wire

// ### logic/lpp_lp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface lpp_lp_if;
    logic lp_sync;
    logic lp_on;
    logic lp_busy;

    modport seq (input lp_sync, output lp_on, output lp_busy);
    modport ctrl (output lp_sync, input lp_on, input lp_busy);
endinterface

`default_nettype wire

// ### logic/lpp_lp_seq.sv
`timescale 1ns/1ps
`default_nettype none

module lpp_lp_seq (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    lpp_lp_if.seq lp
);
    import lpp_pkg::*;

    typedef enum logic [1:0] {LPP_RUN, LPP_ENTER, LPP_LOW, LPP_EXIT} lpp_state_t;

    localparam logic [LP_CNT_W-1:0] ENTRY_LAST = LP_CNT_W'(LP_ENTRY_WAIT - 1);
    localparam logic [LP_CNT_W-1:0] EXIT_LAST = LP_CNT_W'(LP_EXIT_WAIT - 1);

    lpp_state_t state_r;
    logic [LP_CNT_W-1:0] cnt_r;
    logic lp_on_r;

    // Power is only switched at the end of a full count, never midway
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_r <= LPP_RUN;
            cnt_r <= '0;
            lp_on_r <= 1'b0;
        end else begin
            unique case (state_r)
                LPP_RUN: begin
                    cnt_r <= '0;
                    if (lp.lp_sync) begin
                        state_r <= LPP_ENTER;
                    end
                end
                LPP_ENTER: begin
                    if (!lp.lp_sync) begin
                        state_r <= LPP_RUN;
                    end else if (cnt_r == ENTRY_LAST) begin
                        state_r <= LPP_LOW;
                        lp_on_r <= 1'b1;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                LPP_LOW: begin
                    cnt_r <= '0;
                    if (!lp.lp_sync) begin
                        state_r <= LPP_EXIT;
                    end
                end
                LPP_EXIT: begin
                    // A new request mid-exit returns straight to low power
                    if (lp.lp_sync) begin
                        state_r <= LPP_LOW;
                        cnt_r <= '0;
                    end else if (cnt_r == EXIT_LAST) begin
                        state_r <= LPP_RUN;
                        lp_on_r <= 1'b0;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    assign lp.lp_on = lp_on_r;
    assign lp.lp_busy = (state_r == LPP_ENTER) || (state_r == LPP_EXIT);

    a_entry_delay: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $rose(lp_on_r) |-> $past(lp.lp_sync, 6) && $past(lp.lp_sync, 1))
        else $error("low power entered without a full entry count");
    a_lp_holds: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lp_on_r && lp.lp_sync |=> lp_on_r)
        else $error("low power left while pin still high");
    a_exit_bound: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        state_r == LPP_EXIT |-> cnt_r <= EXIT_LAST)
        else $error("exit count overran its bound");
    a_run_powered: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        state_r == LPP_RUN |-> !lp_on_r)
        else $error("run state with low power flag set");

    c_entry: cover property (@(posedge core_clk_in) disable iff (!resetn_in) $rose(lp_on_r));
    c_exit: cover property (@(posedge core_clk_in) disable iff (!resetn_in) $fell(lp_on_r));
    c_abort: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        state_r == LPP_ENTER ##1 state_r == LPP_RUN);
endmodule

`default_nettype wire

// ### logic/lpp_pin_ctrl.sv
// Contract
// - A high level on the low-power pin commands entry into the low-power state.
// - In low power every user I/O floats, input buffers read zero and the core is switched off.
// - Low-power entry completes 800 ns after the pin rises; the logic takes 900 ns (nine cycles).
// - Normal operation resumes within 200 us after the pin falls; the logic takes 2001 cycles (200.1 us).
// - The mode pin selects the role of download clock, both probes, serial in and serial out.
// - Each probe output drives the value of a chosen internal node, both usable together.
// - Probe duty exists only with mode high; with mode low these pins are plain user I/O.
// - A permanent lock disables the probes so internal nodes cannot be observed.
// - The serial input takes diagnostic and programming data only while mode is high.
// - The serial output delivers diagnostic and programming data while mode is high or a checksum runs.
// - While a checksum runs the serial output is driven, then returns to user I/O.
// - Each quadrant clock pin is a register control when so used, otherwise user I/O.
`timescale 1ns/1ps
`default_nettype none

module lpp_pin_ctrl (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic low_power_pin_in,
    input wire logic mode_pin_in,
    input wire logic probe_lock_in,
    input wire logic checksum_busy_in,
    input wire logic download_clock_in,
    input wire logic probe_node_a_in,
    input wire logic probe_node_b_in,
    input wire logic diag_tx_data_in,
    input wire logic [lpp_pkg::MF_NUM-1:0] mf_pin_in,
    output logic [lpp_pkg::MF_NUM-1:0] mf_pin_out,
    output logic [lpp_pkg::MF_NUM-1:0] mf_pin_oe_n_out,
    input wire logic [lpp_pkg::MF_NUM-1:0] user_mf_data_in,
    input wire logic [lpp_pkg::MF_NUM-1:0] user_mf_oe_in,
    output logic [lpp_pkg::MF_NUM-1:0] user_mf_data_out,
    input wire logic [lpp_pkg::QCLK_NUM-1:0] quadrant_clock_inputs_in,
    output logic [lpp_pkg::QCLK_NUM-1:0] quadrant_clock_pin_out,
    output logic [lpp_pkg::QCLK_NUM-1:0] quadrant_clock_oe_n_out,
    input wire logic [lpp_pkg::QCLK_NUM-1:0] qclk_ctrl_sel_in,
    input wire logic [lpp_pkg::QCLK_NUM-1:0] user_qclk_data_in,
    input wire logic [lpp_pkg::QCLK_NUM-1:0] user_qclk_oe_in,
    output logic [lpp_pkg::QCLK_NUM-1:0] user_qclk_data_out,
    output logic [lpp_pkg::QCLK_NUM-1:0] qclk_ctrl_out,
    output logic diag_rx_data_out,
    output logic download_clock_out,
    output logic diag_mode_out,
    output logic core_enable_out,
    output logic low_power_out
);
    import lpp_pkg::*;

    // Role of a multifunction pin, decoded from its slot, mode, checksum, lock and low power
    function automatic lpp_role_t mf_role(input int unsigned slot, input logic diag,
                                          input logic chk, input logic locked, input logic lp);
        lpp_role_t role;
        role = LPP_ROLE_USER;
        if (lp) begin
            role = LPP_ROLE_OFF;
        end else if (slot == MF_SER_OUT && (diag || chk)) begin
            role = LPP_ROLE_DRIVE;
        end else if (diag && slot == MF_SER_IN) begin
            role = LPP_ROLE_LISTEN;
        end else if (diag) begin
            // A locked probe floats rather than exposing the node
            role = locked ? LPP_ROLE_OFF : LPP_ROLE_DRIVE;
        end
        return role;
    endfunction

    logic [SY_W-1:0] raw_in;
    logic [SY_W-1:0] sync1_r;
    logic [SY_W-1:0] sync2_r;
    logic lock_r;
    logic [MF_NUM-1:0] mf_drive;
    lpp_lp_if lp_if ();

    assign raw_in = {quadrant_clock_inputs_in, mf_pin_in, download_clock_in,
                     checksum_busy_in, probe_lock_in, mode_pin_in, low_power_pin_in};

    // Every pin passes two stages before any logic looks at it
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    logic lp_s;
    logic mode_s;
    logic chk_s;
    logic lp_on;
    assign lp_s = sync2_r[SY_LP];
    assign mode_s = sync2_r[SY_MODE];
    assign chk_s = sync2_r[SY_CHK];
    assign lp_if.lp_sync = lp_s;
    assign lp_on = lp_if.lp_on;

    lpp_lp_seq u_seq (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .lp(lp_if.seq)
    );

    // Fuse level is caught after reset and never released until the next reset
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            lock_r <= 1'b0;
        end else if (sync2_r[SY_LOCK]) begin
            lock_r <= 1'b1;
        end
    end

    // Fuse level gates the probes in the same cycle as mode, so no node leaks out
    logic locked;
    assign locked = lock_r || sync2_r[SY_LOCK];

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            core_enable_out <= 1'b0;
            low_power_out <= 1'b0;
            diag_mode_out <= 1'b0;
        end else begin
            core_enable_out <= !lp_on;
            low_power_out <= lp_on;
            diag_mode_out <= mode_s && !lp_on;
        end
    end

    // Diagnostic receive side: serial in and download clock
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            diag_rx_data_out <= 1'b0;
            download_clock_out <= 1'b0;
        end else begin
            diag_rx_data_out <= mode_s && !lp_on && sync2_r[SY_MF + MF_SER_IN];
            download_clock_out <= mode_s && !lp_on && sync2_r[SY_DOWNLOAD_CLOCK];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < MF_NUM; gi++) begin : g_mf
            lpp_role_t role;
            logic diag_val;
            assign role = mf_role(gi, mode_s, chk_s, locked, lp_on);
            if (gi == MF_PROBE_A) begin : g_a
                assign diag_val = probe_node_a_in;
            end else if (gi == MF_PROBE_B) begin : g_b
                assign diag_val = probe_node_b_in;
            end else begin : g_s
                assign diag_val = diag_tx_data_in;
            end
            assign mf_drive[gi] = (role == LPP_ROLE_DRIVE);

            always_ff @(posedge core_clk_in) begin
                if (!resetn_in) begin
                    mf_pin_out[gi] <= 1'b0;
                    mf_pin_oe_n_out[gi] <= 1'b1;
                    user_mf_data_out[gi] <= 1'b0;
                end else begin
                    unique case (role)
                        LPP_ROLE_USER: begin
                            mf_pin_out[gi] <= user_mf_data_in[gi];
                            mf_pin_oe_n_out[gi] <= !user_mf_oe_in[gi];
                            user_mf_data_out[gi] <= sync2_r[SY_MF + gi];
                        end
                        LPP_ROLE_DRIVE: begin
                            mf_pin_out[gi] <= diag_val;
                            mf_pin_oe_n_out[gi] <= 1'b0;
                            user_mf_data_out[gi] <= 1'b0;
                        end
                        LPP_ROLE_LISTEN: begin
                            mf_pin_out[gi] <= 1'b0;
                            mf_pin_oe_n_out[gi] <= 1'b1;
                            user_mf_data_out[gi] <= 1'b0;
                        end
                        LPP_ROLE_OFF: begin
                            mf_pin_out[gi] <= 1'b0;
                            mf_pin_oe_n_out[gi] <= 1'b1;
                            user_mf_data_out[gi] <= 1'b0;
                        end
                    endcase
                end
            end
        end

        for (gi = 0; gi < QCLK_NUM; gi++) begin : g_qclk
            // A pin used as register control never drives and never feeds user input
            always_ff @(posedge core_clk_in) begin
                if (!resetn_in) begin
                    quadrant_clock_pin_out[gi] <= 1'b0;
                    quadrant_clock_oe_n_out[gi] <= 1'b1;
                    user_qclk_data_out[gi] <= 1'b0;
                    qclk_ctrl_out[gi] <= 1'b0;
                end else if (lp_on) begin
                    quadrant_clock_pin_out[gi] <= 1'b0;
                    quadrant_clock_oe_n_out[gi] <= 1'b1;
                    user_qclk_data_out[gi] <= 1'b0;
                    qclk_ctrl_out[gi] <= 1'b0;
                end else if (qclk_ctrl_sel_in[gi]) begin
                    quadrant_clock_pin_out[gi] <= 1'b0;
                    quadrant_clock_oe_n_out[gi] <= 1'b1;
                    user_qclk_data_out[gi] <= 1'b0;
                    qclk_ctrl_out[gi] <= sync2_r[SY_QCLK + gi];
                end else begin
                    quadrant_clock_pin_out[gi] <= user_qclk_data_in[gi];
                    quadrant_clock_oe_n_out[gi] <= !user_qclk_oe_in[gi];
                    user_qclk_data_out[gi] <= sync2_r[SY_QCLK + gi];
                    qclk_ctrl_out[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    a_lp_float: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lp_on |=> (&mf_pin_oe_n_out) && (&quadrant_clock_oe_n_out)
                  && !core_enable_out && user_mf_data_out == '0)
        else $error("pin driven or core on during low power");
    a_probe_node: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        mode_s && !lp_on && !locked |=> !mf_pin_oe_n_out[MF_PROBE_A]
            && mf_pin_out[MF_PROBE_A] == $past(probe_node_a_in)
            && mf_pin_out[MF_PROBE_B] == $past(probe_node_b_in))
        else $error("probe does not show its node");
    a_user_mode_low: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !mode_s && !lp_on && !chk_s |=> mf_pin_out == $past(user_mf_data_in)
            && mf_pin_oe_n_out == ~$past(user_mf_oe_in))
        else $error("multifunction pins not user I/O with mode low");
    a_probe_lock: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lock_r |=> lock_r && mf_pin_oe_n_out[MF_PROBE_A] && mf_pin_oe_n_out[MF_PROBE_B]
            || !$past(mode_s))
        else $error("locked probe still observable");
    a_serial_rx: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        ##1 diag_rx_data_out |-> $past(mode_s) && !$past(lp_on))
        else $error("serial data taken without mode high");
    a_serial_tx: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (mode_s || chk_s) && !lp_on |=> !mf_pin_oe_n_out[MF_SER_OUT]
            && mf_pin_out[MF_SER_OUT] == $past(diag_tx_data_in))
        else $error("serial output not driven in diagnostic duty");
    a_qclk_ctrl: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        qclk_ctrl_out != '0 |-> $past(qclk_ctrl_sel_in) != '0)
        else $error("quadrant control out without selection");
    a_mode_role: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $rose(mode_s) && !lp_on |=> diag_mode_out)
        else $error("mode rise not reflected");
    a_no_drive_lp: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lp_on |-> mf_drive == '0)
        else $error("diagnostic drive selected in low power");
    a_no_partial_power: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lp_if.lp_busy |=> core_enable_out != low_power_out)
        else $error("partial power state shown while sequencer counts");

    c_probe: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        !mf_pin_oe_n_out[MF_PROBE_A] && !mf_pin_oe_n_out[MF_PROBE_B] && diag_mode_out);
    c_checksum: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        chk_s && !mode_s && !lp_on);
endmodule

`default_nettype wire

// ### test/lpp_far_pad.sv
`timescale 1ns/1ps
`default_nettype none

// Board side of a group of pads: the device, the debug tool or the pull-down
module lpp_far_pad #(
    parameter int W = 4
) (
    input wire logic [W-1:0] dev_data_in,
    input wire logic [W-1:0] dev_oe_n_in,
    input wire logic [W-1:0] tool_data_in,
    input wire logic [W-1:0] tool_en_in,
    output logic [W-1:0] pad_out
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            // Two drivers at once is a board fault, so it shows as unknown
            if (!dev_oe_n_in[i] && tool_en_in[i]) begin
                pad_out[i] = 1'bx;
            end else if (!dev_oe_n_in[i]) begin
                pad_out[i] = dev_data_in[i];
            end else if (tool_en_in[i]) begin
                pad_out[i] = tool_data_in[i];
            end else begin
                pad_out[i] = 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lpp_pkg::*;
    logic clk = 1'b0, rstn, lp, mode, lock, chk, download_clock, nd_a, nd_b, tx;
    logic rx, download_clock_q, dmode, core_en, lp_q;
    logic [3:0] mf_in, mf_out, mf_oe_n, umf_d, umf_oe, umf_q, tmf, tmf_en;
    logic [3:0] q_in, q_out, q_oe_n, q_sel, uq_d, uq_oe, uq_q, q_ctrl, tq, tq_en;
    int errors = 0, num_checks = 0, cycles = 0;

    always #50 clk = ~clk;

    lpp_pin_ctrl uut (.core_clk_in(clk), .resetn_in(rstn), .low_power_pin_in(lp),
        .mode_pin_in(mode), .probe_lock_in(lock), .checksum_busy_in(chk),
        .download_clock_in(download_clock), .probe_node_a_in(nd_a), .probe_node_b_in(nd_b),
        .diag_tx_data_in(tx), .mf_pin_in(mf_in), .mf_pin_out(mf_out),
        .mf_pin_oe_n_out(mf_oe_n), .user_mf_data_in(umf_d), .user_mf_oe_in(umf_oe),
        .user_mf_data_out(umf_q), .quadrant_clock_inputs_in(q_in),
        .quadrant_clock_pin_out(q_out), .quadrant_clock_oe_n_out(q_oe_n),
        .qclk_ctrl_sel_in(q_sel), .user_qclk_data_in(uq_d), .user_qclk_oe_in(uq_oe),
        .user_qclk_data_out(uq_q), .qclk_ctrl_out(q_ctrl), .diag_rx_data_out(rx),
        .download_clock_out(download_clock_q), .diag_mode_out(dmode), .core_enable_out(core_en),
        .low_power_out(lp_q));
    lpp_far_pad #(.W(4)) mf_pads (.dev_data_in(mf_out), .dev_oe_n_in(mf_oe_n),
        .tool_data_in(tmf), .tool_en_in(tmf_en), .pad_out(mf_in));
    lpp_far_pad #(.W(4)) q_pads (.dev_data_in(q_out), .dev_oe_n_in(q_oe_n),
        .tool_data_in(tq), .tool_en_in(tq_en), .pad_out(q_in));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs about 2130 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic cmp1(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // Pad inputs take three edges to reach the outputs
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic t_user_io();
        @(posedge clk);
        tmf <= 4'ha;
        tmf_en <= 4'hf;
        settle();
        cmp4(umf_q, 4'ha, "user pad read");
        cmp4(mf_oe_n, 4'hf, "pads not floating");
        cmp1(dmode, 1'b0, "diag mode with mode low");
        @(posedge clk);
        tmf_en <= 4'h0;
        umf_d <= 4'h5;
        umf_oe <= 4'hf;
        settle();
        cmp4(mf_oe_n, 4'h0, "user drive enable");
        cmp4(mf_out, 4'h5, "user drive value");
        $display("test user_io done");
    endtask

    task automatic t_probe();
        @(posedge clk);
        mode <= 1'b1;
        nd_a <= 1'b1;
        tx <= 1'b1;
        download_clock <= 1'b1;
        tmf <= 4'h4;
        umf_oe <= 4'h0;
        // Tool waits until the user drive on serial in has let go
        @(posedge clk);
        tmf_en <= 4'h4;
        settle();
        cmp1(dmode, 1'b1, "diag mode");
        cmp4(mf_oe_n, 4'h4, "probe and serial out drive");
        cmp4(mf_out & 4'hb, 4'h9, "probe and serial out data");
        cmp1(rx, 1'b1, "serial in");
        cmp1(download_clock_q, 1'b1, "download clock");
        cmp4(umf_q, 4'h0, "user read in mode");
        @(posedge clk);
        nd_a <= 1'b0;
        nd_b <= 1'b1;
        tmf <= 4'h0;
        settle();
        cmp4(mf_out & 4'h3, 4'h2, "probe follows node");
        cmp1(rx, 1'b0, "serial in low");
        @(posedge clk);
        mode <= 1'b0;
        tmf_en <= 4'h0;
        umf_oe <= 4'hf;
        settle();
        cmp4(mf_oe_n, 4'h0, "back to user");
        cmp1(rx, 1'b0, "serial in gated");
        cmp1(download_clock_q, 1'b0, "download clock gated");
        $display("test probe done");
    endtask

    task automatic t_checksum();
        @(posedge clk);
        umf_oe <= 4'h0;
        chk <= 1'b1;
        tx <= 1'b0;
        settle();
        cmp4(mf_oe_n, 4'h7, "serial out driven");
        cmp1(mf_out[3], 1'b0, "checksum data low");
        @(posedge clk);
        tx <= 1'b1;
        @(posedge clk);
        #1;
        cmp1(mf_out[3], 1'b1, "checksum data high");
        @(posedge clk);
        chk <= 1'b0;
        settle();
        cmp4(mf_oe_n, 4'hf, "serial out released");
        $display("test checksum done");
    endtask

    task automatic t_qclk();
        @(posedge clk);
        q_sel <= 4'h3;
        tq <= 4'h5;
        tq_en <= 4'hf;
        settle();
        cmp4(q_ctrl, 4'h1, "quadrant control");
        cmp4(uq_q, 4'h4, "quadrant user read");
        @(posedge clk);
        tq_en <= 4'h3;
        uq_oe <= 4'hc;
        uq_d <= 4'h8;
        settle();
        cmp4(q_oe_n, 4'h3, "quadrant user drive");
        cmp4(q_out & 4'hc, 4'h8, "quadrant user value");
        $display("test qclk done");
    endtask

    task automatic t_low_power();
        @(posedge clk);
        umf_oe <= 4'hf;
        lp <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        cmp1(lp_q, 1'b0, "entry too early");
        @(posedge clk);
        #1;
        cmp1(lp_q, 1'b1, "entry late");
        cmp1(core_en, 1'b0, "core still on");
        cmp4(mf_oe_n, 4'hf, "pads driven in low power");
        cmp4(q_oe_n, 4'hf, "quadrant pads driven");
        cmp4(uq_q, 4'h0, "input buffers on");
        @(posedge clk);
        lp <= 1'b0;
        repeat (10) @(posedge clk);
        lp <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        cmp1(lp_q, 1'b1, "re-raise left low power");
        cmp1(core_en, 1'b0, "re-raise core on");
        @(posedge clk);
        lp <= 1'b0;
        repeat (2000) @(posedge clk);
        #1;
        cmp1(lp_q, 1'b1, "exit too early");
        @(posedge clk);
        #1;
        cmp1(lp_q, 1'b0, "exit late");
        cmp1(core_en, 1'b1, "core off after exit");
        cmp4(mf_oe_n, 4'h0, "pads back");
        $display("test low_power done");
    endtask

    task automatic t_lp_abort();
        @(posedge clk);
        lp <= 1'b1;
        repeat (5) @(posedge clk);
        lp <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            @(posedge clk);
            #1;
            cmp1(lp_q, 1'b0, "short pulse entered");
            cmp1(core_en, 1'b1, "short pulse core off");
        end
        $display("test lp_abort done");
    endtask

    task automatic t_lock();
        @(posedge clk);
        lock <= 1'b1;
        mode <= 1'b1;
        settle();
        cmp4(mf_oe_n, 4'h7, "locked probes driven");
        @(posedge clk);
        lock <= 1'b0;
        settle();
        cmp4(mf_oe_n, 4'h7, "lock not sticky");
        $display("test lock done");
    endtask

    initial begin
        rstn = 1'b0;
        {lp, mode, lock, chk, download_clock, nd_a, nd_b, tx} = 8'h00;
        {umf_d, umf_oe, tmf, tmf_en} = 16'h0000;
        {q_sel, uq_d, uq_oe, tq, tq_en} = 20'h00000;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp4(mf_oe_n, 4'hf, "reset pad enable");
        cmp1(core_en, 1'b0, "reset core enable");
        @(posedge clk);
        @(posedge clk);
        #1;
        cmp1(core_en, 1'b1, "core enable after reset");
        t_user_io();
        t_probe();
        t_checksum();
        t_qclk();
        t_low_power();
        t_lp_abort();
        t_lock();
        print_verdict();
    end
endmodule

`default_nettype wire
